//--- core/sgls_link_filter.sv
// link-clock logic: holds sync up through short losses, flags faults
// assumes sync and fault inputs are generated on the link clock itself
module sgls_link_filter #(
  parameter int TIMER_CYCLES = 5000                  // link timer in cycles
) (
  input  wire logic linkClk,                         // link clock
  input  wire logic rstn,                            // async reset, low
  input  wire logic syncRaw,                         // raw sync status
  input  wire logic faultPulse,                      // one-cycle fault event
  output logic      syncFlag,                        // filtered sync level
  output logic      faultToggle                      // flips on each fault
);
  import sgls_pkg::*;

  localparam logic [15:0] TIMER_LAST = 16'(TIMER_CYCLES - 1); // final count

  logic        syncFlag_reg,  syncFlag_next;         // filtered sync
  logic [15:0] lossCnt_reg,   lossCnt_next;          // cycles of loss so far
  logic        faultTog_reg,  faultTog_next;         // fault event toggle

  ////////////////////////////////////////////////////////////////////////////
  // sync only drops after a whole timer of continuous loss
  always_comb
  begin
    syncFlag_next = syncFlag_reg;
    lossCnt_next  = TIMER_ZERO;
    faultTog_next = faultTog_reg ^ faultPulse;       // toggle carries event
    if (syncRaw)
    begin
      syncFlag_next = 1'b1;                          // rises at once
    end
    else if (syncFlag_reg)
    begin
      if (lossCnt_reg == TIMER_LAST)
        syncFlag_next = 1'b0;
      else
        lossCnt_next = lossCnt_reg + TIMER_STEP;
    end
  end

  always_ff @(posedge linkClk or negedge rstn)
  begin
    if (!rstn)
    begin
      syncFlag_reg <= 1'b0;
      lossCnt_reg  <= TIMER_ZERO;
      faultTog_reg <= 1'b0;
    end
    else
    begin
      syncFlag_reg <= syncFlag_next;
      lossCnt_reg  <= lossCnt_next;
      faultTog_reg <= faultTog_next;
    end
  end

  assign syncFlag    = syncFlag_reg;
  assign faultToggle = faultTog_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the link side
  a_loss_full_timer : assert property (
    @(posedge linkClk) disable iff (!rstn)
    $fell(syncFlag_reg) |-> ($past(lossCnt_reg) == TIMER_LAST)
                            && !$past(syncRaw))
    else $error("sync dropped before a full link timer");

  a_loss_holds_up : assert property (
    @(posedge linkClk) disable iff (!rstn)
    (syncFlag_reg && !syncRaw && lossCnt_reg != TIMER_LAST) |=> syncFlag_reg)
    else $error("sync fell while link timer still running");

endmodule : sgls_link_filter

//--- core/sgls_pkg.sv
// constants, carriers and states for the serial link status word
// assumes one management read port and one link-side clock domain
package sgls_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // word layout and address
  localparam int          WORD_W        = 16;         // status word width
  localparam int          ADDR_W        = 5;          // register number width
  localparam logic [4:0]  STATUS_REG_NUM = 5'h01;     // link status word
  localparam int          BIT_AN_DONE   = 5;          // negotiation finished
  localparam int          BIT_FAULT     = 4;          // remote fault, sticky
  localparam int          BIT_LINK      = 2;          // link status, latch low
  // constant part of the word: bits 8, 7, 6 and 3 set, all others zero
  localparam logic [15:0] FIXED_ONES    = 16'h01C8;   // ext, unidir, pre, abil
  localparam logic [15:0] LIVE_MASK     = 16'h0034;   // bits 5, 4 and 2
  localparam logic [15:0] UPPER_MASK    = 16'hFE00;   // bits 15 down to 9
  localparam logic [15:0] LOWER_MASK    = 16'h0003;   // bits 1 and 0
  localparam logic [15:0] WORD_ZERO     = 16'h0000;   // unmapped answer
  localparam logic [15:0] TIMER_ZERO    = 16'h0000;   // loss counter reset
  localparam logic [15:0] TIMER_STEP    = 16'h0001;   // loss counter step

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic              strobe;                       // two-cycle read request
    logic [ADDR_W-1:0] regNum;                       // register number
  } sgls_rd_req_t;

  typedef struct packed {
    logic anDone;                                    // negotiation finished
    logic syncFlag;                                  // filtered sync level
    logic faultToggle;                               // flips once per fault
  } sgls_live_t;

  // read sequencing: word captured, waiting for the read to finish
  typedef enum logic {
    RD_IDLE,
    RD_WAIT_DONE
  } sgls_rd_state_t;

endpackage : sgls_pkg

//--- core/sgls_status_word.sv
// link status word of one serial channel, read through the management port
// assumes a frame engine on sys_clk that issues reads and marks their end;
// live inputs come from sync and negotiation logic on the link clock
//
// Overview of operation
// - bits fifteen to nine read zero always
// - bit eight reads one: extended status present
// - unidirectional ability bit reads one, writes ignored
// - preamble-free management frames bit reads one
// - bit five shows negotiation finished, read only
// - remote fault sticks until read clears it
// - negotiation ability bit always reads one
// - link bit latches low, read reloads it
// - link one needs sync kept and, if enabled, negotiation
// - bits one and zero read zero always
// - sync loss must last a timer first
module sgls_status_word #(
  parameter int LINK_TIMER_CYCLES = 5000             // link timer, link clks
) (
  input  wire logic                 sys_clk,         // management clock
  input  wire logic                 rstn,            // async reset, low
  input  wire logic                 linkClk,         // link clock
  input  wire logic                 linkSyncRaw,     // raw sync, link domain
  input  wire logic                 linkAnDone,      // negotiation finished
  input  wire logic                 linkFaultPulse,  // fault event, link dom
  input  wire logic                 anEnable,        // negotiation enable
  input  wire sgls_pkg::sgls_rd_req_t rdReq,         // read request
  input  wire logic                 rdDone,          // read has finished
  output logic [15:0]               rdData,          // captured word
  output logic                      rdValid,         // word is ready, pulse
  output logic                      rdHit            // address was mapped
);
  import sgls_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  sgls_live_t     linkLive;                          // link-domain levels
  sgls_live_t     sysLive;                           // after two flops
  logic           linkSyncFlag;                      // filtered sync
  logic           linkFaultTog;                      // fault toggle
  logic           faultTogSeen_reg;                  // last toggle value
  logic           faultEvent;                        // one fault, sys domain
  logic           liveLink;                          // present link state

  sgls_rd_state_t rdState_reg,    rdState_next;      // read sequencing
  logic [15:0]    rdData_reg,     rdData_next;       // word returned
  logic           rdValid_reg,    rdValid_next;      // answer pulse
  logic           rdHit_reg,      rdHit_next;        // mapped flag
  logic           faultLatch_reg, faultLatch_next;   // sticky fault
  logic           linkLatch_reg,  linkLatch_next;    // latch-low link
  logic           lostInRd_reg,   lostInRd_next;     // loss while reading
  logic           doneTaken;                         // read end accepted

  ////////////////////////////////////////////////////////////////////////////
  // word assembly, used only by the capture
  function automatic logic [15:0] build_word(
    input logic anDone,
    input logic fault,
    input logic link
  );
    logic [15:0] word;
    // fixed ones and zeros
    // and
    word            = FIXED_ONES;
    word[BIT_AN_DONE] = anDone;
    word[BIT_FAULT] = fault;
    word[BIT_LINK]  = link;
    return word;
  endfunction : build_word

  // address decode used by the capture; the checks use rdHit_reg instead
  function automatic logic is_status_reg(input logic [ADDR_W-1:0] regNum);
    return regNum == STATUS_REG_NUM;
  endfunction : is_status_reg

  ////////////////////////////////////////////////////////////////////////////
  // link-clock side: timer on sync loss and fault toggle
  sgls_link_filter #(
    .TIMER_CYCLES (LINK_TIMER_CYCLES)
  ) u_link_filter (
    .linkClk      (linkClk),
    .rstn         (rstn),
    .syncRaw      (linkSyncRaw),
    .faultPulse   (linkFaultPulse),
    .syncFlag     (linkSyncFlag),
    .faultToggle  (linkFaultTog)
  );

  assign linkLive.anDone      = linkAnDone;
  assign linkLive.syncFlag    = linkSyncFlag;
  assign linkLive.faultToggle = linkFaultTog;

  // the three levels are independent, so a per-bit sync is enough;
  // the fault toggle must not flip twice within three sys clocks
  sgls_sync2 #(
    .WIDTH    ($bits(sgls_live_t))
  ) u_live_sync (
    .clk      (sys_clk),
    .rstn     (rstn),
    .async_in (linkLive),
    .sync_out (sysLive)
  );

  ////////////////////////////////////////////////////////////////////////////
  // toggle edge back into a one-cycle fault event
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      faultTogSeen_reg <= 1'b0;
    else
      faultTogSeen_reg <= sysLive.faultToggle;
  end

  assign faultEvent = sysLive.faultToggle ^ faultTogSeen_reg;

  // link counts as up only with sync and, if enabled, finished negotiation
  assign liveLink = sysLive.syncFlag
                    && (sysLive.anDone || !anEnable);

  assign doneTaken = (rdState_reg == RD_WAIT_DONE) && rdDone;

  ////////////////////////////////////////////////////////////////////////////
  // read capture and sequencing; a new request is ignored while waiting
  always_comb
  begin
    rdState_next = rdState_reg;
    rdData_next  = rdData_reg;
    rdValid_next = 1'b0;
    rdHit_next   = rdHit_reg;
    case (rdState_reg)
      RD_IDLE:
      begin
        if (rdReq.strobe)
        begin
          rdValid_next = 1'b1;
          rdState_next = RD_WAIT_DONE;
          if (is_status_reg(rdReq.regNum))
          begin
            // latched values go out before anything changes
            rdData_next = build_word(sysLive.anDone, faultLatch_reg,
                                     linkLatch_reg);
            rdHit_next  = 1'b1;
          end
          else
          begin
            rdData_next = WORD_ZERO;                 // unmapped: zero
            rdHit_next  = 1'b0;
          end
        end
      end
      RD_WAIT_DONE:
      begin
        if (rdDone)
          rdState_next = RD_IDLE;
      end
      default:
      begin
        rdState_next = RD_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky bits; events win over the clear of the same cycle
  always_comb
  begin
    // clear only when a read of this word has finished
    // a fault that came after the capture was never reported, so only
    // a fault that went out in the word is cleared
    faultLatch_next = faultEvent
                      || (faultLatch_reg && !(doneTaken && rdHit_reg
                                              && rdData_reg[BIT_FAULT]));
    lostInRd_next   = 1'b0;
    linkLatch_next  = linkLatch_reg;
    if (doneTaken && rdHit_reg)
    begin
      // reload with the present state unless it dropped during the read
      linkLatch_next = liveLink && !lostInRd_reg;
    end
    else
    begin
      if (!liveLink)
        linkLatch_next = 1'b0;
      // a drop in the capture cycle itself is not in the word yet
      if (rdState_reg == RD_WAIT_DONE)
        lostInRd_next = lostInRd_reg || !liveLink;
      else if (rdReq.strobe)
        lostInRd_next = !liveLink;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers of the read side
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdState_reg    <= RD_IDLE;
      rdData_reg     <= WORD_ZERO;
      rdValid_reg    <= 1'b0;
      rdHit_reg      <= 1'b0;
      faultLatch_reg <= 1'b0;
      linkLatch_reg  <= 1'b0;
      lostInRd_reg   <= 1'b0;
    end
    else
    begin
      rdState_reg    <= rdState_next;
      rdData_reg     <= rdData_next;
      rdValid_reg    <= rdValid_next;
      rdHit_reg      <= rdHit_next;
      faultLatch_reg <= faultLatch_next;
      linkLatch_reg  <= linkLatch_next;
      lostInRd_reg   <= lostInRd_next;
    end
  end

  assign rdData  = rdData_reg;
  assign rdValid = rdValid_reg;
  assign rdHit   = rdHit_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks on the management side
  a_upper_bits_zero : assert property (
    @(posedge sys_clk) disable iff (!rstn)
    rdValid_reg |-> (rdData_reg & UPPER_MASK) == WORD_ZERO)
    else $error("bits 15 to 9 not zero");

  a_ext_status_one : assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (rdValid_reg && rdHit_reg) |-> rdData_reg[8])
    else $error("extended status bit not one");

  a_unidir_bit_one : assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (rdValid_reg && rdHit_reg) |-> rdData_reg[7])
    else $error("unidirectional ability bit not one");

  a_preamble_skip_one : assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (rdValid_reg && rdHit_reg) |-> rdData_reg[6])
    else $error("preamble skip bit not one");

  a_an_done_tracks : assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (rdValid_reg && rdHit_reg)
      |-> rdData_reg[BIT_AN_DONE] == $past(sysLive.anDone))
    else $error("negotiation done bit wrong");

  a_fault_sets : assert property (
    @(posedge sys_clk) disable iff (!rstn)
    faultEvent |=> faultLatch_reg [*1] ##1 1'b1)
    else $error("fault event not latched");

  a_fault_sticks : assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (faultLatch_reg && !doneTaken) |=> faultLatch_reg)
    else $error("fault cleared without a read");

  a_fault_unreported : assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (doneTaken && rdHit_reg && faultLatch_reg && !rdData_reg[BIT_FAULT])
      |=> faultLatch_reg)
    else $error("unreported fault cleared by read end");

  a_capture_loss_kept : assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (rdReq.strobe && rdState_reg == RD_IDLE && !liveLink) |=> lostInRd_reg)
    else $error("link loss in capture cycle not kept");

  a_an_ability_one : assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (rdValid_reg && rdHit_reg) |-> rdData_reg[3])
    else $error("negotiation ability bit not one");

  a_link_low_holds : assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (!linkLatch_reg && !doneTaken) |=> !linkLatch_reg)
    else $error("link bit rose without a read");

  a_link_reloads : assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (doneTaken && rdHit_reg)
      |=> linkLatch_reg == $past(liveLink && !lostInRd_reg))
    else $error("link bit not reloaded on read end");

  a_link_qualified : assert property (
    @(posedge sys_clk) disable iff (!rstn)
    $rose(linkLatch_reg)
      |-> $past(sysLive.syncFlag && (sysLive.anDone || !anEnable)))
    else $error("link bit rose without sync and negotiation");

  a_lower_bits_zero : assert property (
    @(posedge sys_clk) disable iff (!rstn)
    rdValid_reg |-> (rdData_reg & LOWER_MASK) == WORD_ZERO)
    else $error("bits 1 and 0 not zero");

  a_update_after_read : assert property (
    @(posedge sys_clk) disable iff (!rstn)
    !$past(doneTaken) |-> !$fell(faultLatch_reg) && !$rose(linkLatch_reg))
    else $error("latched bits changed before read end");

  a_answer_one_cycle : assert property (
    @(posedge sys_clk) disable iff (!rstn)
    (rdReq.strobe && rdState_reg == RD_IDLE) |=> rdValid_reg ##1 !rdValid_reg)
    else $error("read answer not a one-cycle pulse");

endmodule : sgls_status_word

//--- core/sgls_sync2.sv
// two-flop synchroniser for a group of independent levels
// assumes each bit is a level that holds for several destination clocks
module sgls_sync2 #(
  parameter int WIDTH = 1                            // number of levels
) (
  input  wire logic             clk,                 // destination clock
  input  wire logic             rstn,                // async reset, low
  input  wire logic [WIDTH-1:0] async_in,            // foreign-domain levels
  output logic      [WIDTH-1:0] sync_out             // synchronised levels
);

  logic [WIDTH-1:0] stage1_reg;                      // metastable stage
  logic [WIDTH-1:0] stage2_reg;                      // settled stage

  ////////////////////////////////////////////////////////////////////////////
  // only the second stage reads the first one
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end
    else
    begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule : sgls_sync2

//--- verif/sgls_mgmt_ctrl.sv
// management controller model: issues reads of the link status word
// assumes the read port of the status word block, all on sys_clk
module sgls_mgmt_ctrl (
  input  wire logic            sys_clk,  // management clock
  output sgls_pkg::sgls_rd_req_t rdReq,  // read request
  output logic                 rdDone,   // read finished, pulse
  output logic                 anEnable, // negotiation enable, ctrl bit
  input  wire logic [15:0]     rdData,   // captured word
  input  wire logic            rdValid,  // answer pulse
  input  wire logic            rdHit     // address was mapped
);
  import sgls_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // idle values from time zero; negotiation enabled as after reset
  initial
  begin
    rdReq    = '0;
    rdDone   = 1'b0;
    anEnable = 1'b1;
  end

  // control bit of register 0; the caller changes it off the clock edge
  task automatic set_enable(input logic e);
    anEnable = e;
  endtask : set_enable

  // one read: two-cycle strobe, wait for the answer, end the read gap
  // cycles later; gap 0 ends it in the answer cycle itself
  task automatic read(input logic [4:0] num, input int gap,
                      output logic [15:0] word, output logic hit);
    int n;
    n = 0;
    @(negedge sys_clk);
    rdReq = {1'b1, num};
    @(negedge sys_clk);
    while (rdValid !== 1'b1 && n < 4)
    begin
      @(negedge sys_clk);
      n++;
    end
    // no answer gives an unknown word so the caller sees a mismatch
    word = (n < 4) ? rdData : 'x;
    hit  = rdHit;
    // the request stands over the edge that samples the answer
    if (gap == 0)
      rdDone = 1'b1;
    @(negedge sys_clk);
    // released address lines must not keep the old value
    rdReq = {1'b0, ~num};
    if (gap > 0)
    begin
      repeat (gap - 1) @(negedge sys_clk);
      rdDone = 1'b1;
      @(negedge sys_clk);
    end
    rdDone = 1'b0;
  endtask : read

  // a zero link bit may only record an old loss, so read once more
  task automatic confirm(input int gap, output logic [15:0] first,
                         output logic [15:0] second);
    logic hit;
    read(STATUS_REG_NUM, gap, first, hit);
    second = first;
    if (first[BIT_LINK] !== 1'b1)
      read(STATUS_REG_NUM, gap, second, hit);
  endtask : confirm

endmodule : sgls_mgmt_ctrl

//--- verif/sgls_status_word_tb.sv
// self-checking bench for the link status word
// assumes the management model above and a link clock of 15 ns
module sgls_status_word_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sgls_pkg::*;

  localparam int LT = 8;             // short link timer for simulation
  logic          sys_clk;            // management clock
  logic          rstn;               // async reset, low
  logic          linkClk;            // link clock
  logic          linkSyncRaw;        // raw sync
  logic          linkAnDone;         // negotiation finished
  logic          linkFaultPulse;     // fault event
  logic          anEnable;           // negotiation enable
  sgls_rd_req_t  rdReq;              // read request
  logic          rdDone;             // read finished
  logic [15:0]   rdData;             // captured word
  logic          rdValid;            // answer pulse
  logic          rdHit;              // mapped address
  logic          latchM, faultM;     // model latches
  logic          liveM, anM;         // model live levels
  int            error_cnt;          // mismatches
  int            comparisons;        // compares made
  logic [15:0]   w1, w2;             // words of a double read

  ////////////////////////////////////////////////////////////////////////////
  // clocks: the link clock is offset so edges never line up
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial
  begin
    linkClk = 1'b0;
    #3.7;
    forever #7.5 linkClk = ~linkClk;
  end

  sgls_status_word #(.LINK_TIMER_CYCLES(LT)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .linkClk(linkClk),
    .linkSyncRaw(linkSyncRaw), .linkAnDone(linkAnDone),
    .linkFaultPulse(linkFaultPulse), .anEnable(anEnable),
    .rdReq(rdReq), .rdDone(rdDone), .rdData(rdData),
    .rdValid(rdValid), .rdHit(rdHit));

  sgls_mgmt_ctrl ctl (
    .sys_clk(sys_clk), .rdReq(rdReq), .rdDone(rdDone),
    .anEnable(anEnable), .rdData(rdData), .rdValid(rdValid),
    .rdHit(rdHit));

  ////////////////////////////////////////////////////////////////////////////
  // compare one value, report at once on a difference
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // judge one answer against the model, then apply the read's end
  task automatic judge(input logic [4:0] num, input logic [15:0] w,
                       input logic h);
    logic [15:0] live;
    live = {10'h000, anM, faultM, 1'b0, latchM, 2'h0};
    check({15'h0000, h}, {15'h0000, num == 5'h01});
    if (num != 5'h01)
      check(w, 16'h0000);
    else
    begin
      check(w & 16'hFE03, 16'h0000);
      check(w & 16'h0180, 16'h0180);
      check(w & 16'h0048, 16'h0048);
      check(w & 16'h0030, live & 16'h0030);
      check(w & 16'h0004, live & 16'h0004);
      faultM = 1'b0;
      latchM = liveM;
    end
  endtask : judge

  task automatic doRead(input logic [4:0] num, input int gap);
    logic [15:0] w;
    logic        h;
    ctl.read(num, gap, w, h);
    judge(num, w, h);
  endtask : doRead

  // set the live inputs; waits out the link timer and the crossing
  task automatic setLink(input logic s, input logic a, input logic e);
    @(negedge linkClk);
    linkSyncRaw = s;
    linkAnDone  = a;
    @(negedge sys_clk);
    ctl.set_enable(e);
    anM   = a;
    liveM = s & (a | ~e);
    if (!liveM)
      latchM = 1'b0;
    repeat (20) @(negedge sys_clk);
  endtask : setLink

  // sync lost for n link cycles; only n >= LT reaches the status
  task automatic loss(input int n);
    @(negedge linkClk);
    linkSyncRaw = 1'b0;
    repeat (n) @(negedge linkClk);
    linkSyncRaw = 1'b1;
    if (n >= LT)
      latchM = 1'b0;
    repeat (20) @(negedge sys_clk);
  endtask : loss

  task automatic fault();
    @(negedge linkClk);
    linkFaultPulse = 1'b1;
    @(negedge linkClk);
    linkFaultPulse = 1'b0;
    faultM = 1'b1;
    repeat (10) @(negedge sys_clk);
  endtask : fault

  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  // watchdog: the tests need under a thousand cycles, this allows 50000
  initial
  begin
    #1000000;
    error_cnt++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    {linkSyncRaw, linkAnDone, linkFaultPulse, rstn} = 4'h0;
    {latchM, faultM, liveM, anM} = 4'h0;
    error_cnt   = 0;
    comparisons = 0;
    void'($urandom(32'hA3623127));
    repeat (12) @(negedge sys_clk);
    rstn = 1'b1;
    doRead(5'h01, 0);
    $display("test reset word done");
    setLink(1'b1, 1'b1, 1'b1);
    ctl.confirm(2, w1, w2);
    judge(5'h01, w1, rdHit);
    judge(5'h01, w2, rdHit);
    $display("test link up done");
    loss(LT - 1);
    doRead(5'h01, 0);
    loss(LT + 6);
    doRead(5'h01, 1);
    doRead(5'h01, 0);
    $display("test sync loss done");
    fault();
    fault();
    doRead(5'($urandom_range(31, 2)), 3);
    doRead(5'h01, 0);
    doRead(5'h01, 2);
    $display("test fault done");
    setLink(1'b1, 1'b0, 1'b1);
    doRead(5'h01, 1);
    setLink(1'b1, 1'b0, 1'b0);
    doRead(5'h01, 0);
    doRead(5'h01, 4);
    $display("test negotiation done");
    repeat (12)
    begin
      setLink(1'b1, 1'($urandom % 2), 1'b0);
      if ($urandom % 2)
        fault();
      doRead(5'($urandom % 32), $urandom % 5);
    end
    $display("test random reads done");
    fault();
    @(negedge sys_clk);
    rstn = 1'b0;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    {latchM, faultM} = 2'h0;
    repeat (10) @(negedge sys_clk);
    doRead(5'h01, 0);
    $display("test second reset done");
    wrap_up();
  end

endmodule : sgls_status_word_tb
